//--- hw/spi_cfg_pkg.sv
// constants, types and carriers for the serial configuration register map
package spi_cfg_pkg;
   localparam logic [12:0] ADDR_PORT = 13'h0000;
   localparam logic [12:0] ADDR_ID = 13'h0001;
   localparam logic [12:0] ADDR_GRADE = 13'h0002;
   localparam logic [12:0] ADDR_INDEX = 13'h0005;
   localparam logic [12:0] ADDR_XFER = 13'h00FF;
   localparam logic [12:0] ADDR_FUNC_LO = 13'h0008;
   localparam logic [12:0] ADDR_FUNC_HI = 13'h0022;
   localparam int FUNC_N = 27;
   localparam int CLOCK_IDX = 1;
   localparam logic [7:0] PORT_RST = 8'h18;
   localparam logic [7:0] INDEX_RST = 8'h0F;
   localparam logic [7:0] CLOCK_RST = 8'h01;
   localparam int PORT_LSB_HI = 6;
   localparam int PORT_LSB_LO = 1;
   localparam int PORT_SRST_HI = 5;
   localparam int PORT_SRST_LO = 2;
   localparam int GRADE_LSB = 4;
   localparam int XFER_BIT = 0;
   localparam int INSTR_RW = 15;
   localparam int INSTR_WHI = 14;
   localparam int INSTR_WLO = 13;
   // arbitrary identity values, not those of any real part
   localparam logic [7:0] PART_ID_DEF = 8'h5A;
   localparam logic [2:0] GRADE_DEF = 3'h3;
   localparam logic [FUNC_N*8-1:0] FUNCS_RST = (FUNC_N*8)'(CLOCK_RST) << (8 * CLOCK_IDX);

   typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA} phase_t;

   typedef struct packed {
      logic [7:0] dev_index;
      logic [FUNC_N-1:0][7:0] funcs;
   } settings_t;

   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic sdio;
   } pins_t;

   localparam pins_t PINS_IDLE = '{sclk: 1'b0, cs_n: 1'b1, sdio: 1'b0};
   localparam settings_t SET_RST = '{dev_index: INDEX_RST, funcs: FUNCS_RST};

   typedef struct packed {
      phase_t phase;
      logic sclk_prev;
      logic cs_prev;
      logic got_hi;
      logic is_read;
      logic stream;
      logic [2:0] bit_cnt;
      logic [1:0] cnt;
      logic [12:0] addr;
      logic [7:0] shreg;
      logic [7:0] instr_hi;
      logic [7:0] tx;
      logic [7:0] port;
      logic sdio_out;
      logic sdio_oe;
      settings_t hold;
      settings_t active;
   } state_t;
endpackage : spi_cfg_pkg

//--- hw/pin_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3
   import spi_cfg_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input pins_t din,
   output pins_t dout
);
   typedef struct packed {
      pins_t s1;
      pins_t s2;
      pins_t s3;
      pins_t level;
   } sync_t;

   sync_t q;
   sync_t d;

   always_comb begin
      d = q;
      d.s1 = din;
      d.s2 = q.s1;
      d.s3 = q.s2;
      // each bit moves only once stages two and three agree
      for (int i = 0; i < $bits(pins_t); i++) begin
         if (q.s2[i] == q.s3[i]) begin
            d.level[i] = q.s3[i];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '{s1: PINS_IDLE, s2: PINS_IDLE, s3: PINS_IDLE, level: PINS_IDLE};
      end else begin
         q <= d;
      end
   end

   assign dout = q.level;
endmodule : pin_sync3

//--- hw/spi_cfg_regs.sv
// serial configuration port with holding and active register banks
`timescale 1ns/1ps
module spi_cfg_regs
   import spi_cfg_pkg::*;
#(
   parameter logic [7:0] PART_ID = PART_ID_DEF,
   parameter logic [2:0] GRADE = GRADE_DEF
)(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic chip_select_n,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   output logic lsb_first,
   output settings_t settings
);
   localparam state_t ST_RST = '{phase: ST_IDLE, sclk_prev: 1'b0, cs_prev: 1'b1,
      got_hi: 1'b0, is_read: 1'b0, stream: 1'b0, bit_cnt: 3'h0, cnt: 2'h0,
      addr: 13'h0000, shreg: 8'h00, instr_hi: 8'h00, tx: 8'h00, port: PORT_RST,
      sdio_out: 1'b0, sdio_oe: 1'b0, hold: SET_RST, active: SET_RST};

   pins_t pin_raw;
   pins_t pin;
   state_t q;
   state_t d;
   logic rise;
   logic cs_rise;
   logic byte_done;
   logic xfer_ev;
   logic srst_ev;
   logic load_tx;
   logic [7:0] sh;
   logic [15:0] instr;
   logic [12:0] next_addr;

   assign pin_raw = '{sclk: sclk, cs_n: chip_select_n, sdio: sdio_in};

   pin_sync3 u_sync (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .din(pin_raw),
      .dout(pin)
   );

   function automatic logic [4:0] func_idx(input logic [12:0] a);
      logic [12:0] off;
      off = a - ADDR_FUNC_LO;
      return off[4:0];
   endfunction : func_idx

   // unmapped addresses read as zero
   function automatic logic [7:0] rd_byte(input logic [12:0] a, input state_t s);
      logic [7:0] v;
      v = 8'h00;
      if (a == ADDR_PORT) v = s.port;
      else if (a == ADDR_ID) v = PART_ID;
      else if (a == ADDR_GRADE) v = {1'b0, GRADE, 4'h0};
      else if (a == ADDR_INDEX) v = s.hold.dev_index;
      else if (a >= ADDR_FUNC_LO && a <= ADDR_FUNC_HI) v = s.hold.funcs[func_idx(a)];
      return v;
   endfunction : rd_byte

   always_comb begin
      d = q;
      xfer_ev = 1'b0;
      srst_ev = 1'b0;
      load_tx = 1'b0;
      byte_done = 1'b0;
      instr = {q.instr_hi, q.shreg};
      next_addr = q.addr;
      rise = pin.sclk & ~q.sclk_prev;
      cs_rise = pin.cs_n & ~q.cs_prev;
      sh = q.port[PORT_LSB_HI] ? {pin.sdio, q.shreg[7:1]} : {q.shreg[6:0], pin.sdio};
      d.sclk_prev = pin.sclk;
      d.cs_prev = pin.cs_n;
      if (pin.cs_n) begin
         d.sdio_oe = 1'b0;
         // outside streaming, a stall between whole bytes keeps the frame alive
         if (cs_rise && (q.bit_cnt != 3'h0 || q.stream)) begin
            d.phase = ST_IDLE;
            d.bit_cnt = 3'h0;
            d.got_hi = 1'b0;
            d.stream = 1'b0;
         end
      end else begin
         if (q.phase == ST_IDLE) begin
            d.phase = ST_INSTR;
            d.got_hi = 1'b0;
         end
         if (rise) begin
            d.shreg = sh;
            d.bit_cnt = q.bit_cnt + 3'h1;
            byte_done = (q.bit_cnt == 3'h7);
         end
         if (!pin.sclk && q.sclk_prev && q.phase == ST_DATA && q.is_read) begin
            d.sdio_oe = 1'b1;
            d.sdio_out = q.port[PORT_LSB_HI] ? q.tx[q.bit_cnt] : q.tx[3'h7 - q.bit_cnt];
         end
      end
      if (byte_done && q.phase != ST_DATA) begin
         if (!q.got_hi) begin
            d.instr_hi = sh;
            d.got_hi = 1'b1;
         end else begin
            instr = q.port[PORT_LSB_HI] ? {sh, q.instr_hi} : {q.instr_hi, sh};
            d.is_read = instr[INSTR_RW];
            d.cnt = instr[INSTR_WHI:INSTR_WLO];
            d.stream = &instr[INSTR_WHI:INSTR_WLO];
            d.addr = instr[12:0];
            d.phase = ST_DATA;
            d.got_hi = 1'b0;
            d.tx = rd_byte(instr[12:0], q);
            load_tx = 1'b1;
         end
      end else if (byte_done) begin
         if (!q.is_read) begin
            if (q.addr == ADDR_PORT) begin
               d.port = sh;
               srst_ev = sh[PORT_SRST_HI] | sh[PORT_SRST_LO];
            end else if (q.addr == ADDR_INDEX) begin
               d.hold.dev_index = sh;
            end else if (q.addr == ADDR_XFER) begin
               xfer_ev = sh[XFER_BIT];
            end else if (q.addr >= ADDR_FUNC_LO && q.addr <= ADDR_FUNC_HI) begin
               d.hold.funcs[func_idx(q.addr)] = sh;
            end
         end
         next_addr = q.port[PORT_LSB_HI] ? q.addr + 13'h1 : q.addr - 13'h1;
         d.addr = next_addr;
         d.tx = rd_byte(next_addr, q);
         load_tx = 1'b1;
         if (!q.stream) begin
            d.cnt = q.cnt - 2'h1;
            if (q.cnt == 2'h0) begin
               d.phase = ST_IDLE;
               d.sdio_oe = 1'b0;
            end
         end
      end
      if (xfer_ev) begin
         d.active = q.hold;
      end
      // soft reset self-clears, so the port reads back zero in those bits
      if (srst_ev) begin
         d.port = PORT_RST;
         d.hold = SET_RST;
         d.active = SET_RST;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= ST_RST;
      end else begin
         q <= d;
      end
   end

   assign sdio_out = q.sdio_out;
   assign sdio_oe = q.sdio_oe;
   assign lsb_first = q.port[PORT_LSB_HI];
   assign settings = q.active;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   sequence xfer_s;
      xfer_ev && !srst_ev;
   endsequence
   sequence srst_s;
      srst_ev;
   endsequence
   sequence instr_end_s;
      byte_done && q.phase != ST_DATA && q.got_hi;
   endsequence

   a_transfer_copy: assert property (xfer_s |=> settings == $past(q.hold))
      else $error("transfer did not copy holding registers");
   a_active_hold: assert property (!xfer_ev && !srst_ev |=> $stable(settings))
      else $error("active settings changed without transfer");
   a_clock_default: assert property (srst_s |=> settings.funcs[CLOCK_IDX] == CLOCK_RST)
      else $error("clock register default wrong after soft reset");
   a_soft_defaults: assert property (srst_s |=> q.port == PORT_RST && q.hold == SET_RST)
      else $error("defaults not reloaded");
   a_srst_clear: assert property (!q.port[PORT_SRST_HI]
      && !q.port[PORT_SRST_LO])
      else $error("soft reset bit left set");
   a_id_read: assert property (load_tx && d.addr == ADDR_ID |=> q.tx == PART_ID)
      else $error("part identifier read wrong");
   a_grade_read: assert property (load_tx && d.addr == ADDR_GRADE
      |=> q.tx[GRADE_LSB+2:GRADE_LSB] == GRADE && q.tx[3:0] == 4'h0)
      else $error("grade code read wrong");
   a_unmapped_zero: assert property (load_tx
      && (d.addr == 13'h0003 || d.addr == 13'h0023) |=> q.tx == 8'h00)
      else $error("unmapped address not zero");
   a_instr_data: assert property (instr_end_s |=> q.phase == ST_DATA ##1 q.phase != ST_INSTR)
      else $error("instruction did not enter data phase");
   a_cs_abort: assert property (pin.cs_n && cs_rise && q.bit_cnt != 3'h0
      |=> q.phase == ST_IDLE && q.bit_cnt == 3'h0)
      else $error("mid-byte chip select did not reset");
   a_stream_on: assert property (byte_done && q.phase == ST_DATA && q.stream
      && !pin.cs_n |=> q.phase == ST_DATA)
      else $error("streaming stopped early");
   a_msb_default: assert property ($rose(rst_b) |-> !lsb_first)
      else $error("bit order not msb first at start");
   // read-only locations and reads must leave every stored setting alone
   a_ro_write: assert property (byte_done && q.phase == ST_DATA && !q.is_read
      && (q.addr == ADDR_ID || q.addr == ADDR_GRADE) |=> $stable(q.hold) && $stable(q.port))
      else $error("write to read-only location changed a register");
   a_read_no_hold: assert property (byte_done && q.phase == ST_DATA && q.is_read
      |=> $stable(q.hold))
      else $error("read changed holding registers");
   a_port_apply: assert property (byte_done && q.phase == ST_DATA && !q.is_read
      && q.addr == ADDR_PORT && !srst_ev |=> q.port == $past(sh))
      else $error("port setup write not applied");
   a_stream_abort: assert property (cs_rise && q.stream
      |=> q.phase == ST_IDLE && !q.stream)
      else $error("chip select did not end streaming");
   a_oe_read_only: assert property (sdio_oe |-> q.is_read)
      else $error("data pin driven outside a read");
   // the pin must be handed back as soon as the frame closes
   a_oe_cs_off: assert property (pin.cs_n |=> !sdio_oe)
      else $error("data pin still driven with chip select high");
endmodule : spi_cfg_regs

//--- sim/spi_host_model.sv
// serial host model that frames accesses to the configuration port
`timescale 1ns/1ps
module spi_host_model (
   input wire logic sys_clk,
   input wire logic sdio_out,
   input wire logic sdio_oe,
   output logic sclk,
   output logic chip_select_n,
   output logic sdio_line
);
   logic h_sd = 1'b0;
   logic h_en = 1'b0;
   logic lsb = 1'b0;
   logic [7:0] dq [$];
   initial begin
      sclk = 1'b0;
      chip_select_n = 1'b1;
   end
   // released line shows the inverse of the last driven bit, so stale data never passes
   assign sdio_line = sdio_oe ? sdio_out : (h_en ? h_sd : ~sdio_out);
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : cyc
   task automatic cs_set(input logic v);
      chip_select_n <= v;
      h_en <= ~v;
      cyc(v ? 20 : 10);
   endtask : cs_set
   task automatic bit_io(input logic b, input logic drv, output logic s);
      if (drv) h_sd <= b;
      else h_en <= 1'b0;
      cyc(10);
      // read bit taken at sclk rise; device lets go right after the last rise of a counted read, at chip select high when streaming
      s = sdio_line;
      sclk <= 1'b1;
      cyc(10);
      sclk <= 1'b0;
   endtask : bit_io
   task automatic frame(input logic rd, input logic [1:0] w, input logic [12:0] a, input int n);
      logic [15:0] ins;
      logic [7:0] v;
      logic s;
      ins = {rd, w, a};
      cs_set(1'b0);
      for (int i = 0; i < 16; i++) bit_io(ins[lsb ? i : 15 - i], 1'b1, s);
      for (int k = 0; k < n; k++) begin
         v = rd ? 8'h00 : dq[k];
         for (int i = 0; i < 8; i++) begin
            bit_io(v[lsb ? i : 7 - i], !rd, s);
            if (rd) v[lsb ? i : 7 - i] = s;
         end
         if (rd) dq.push_back(v);
      end
      cyc(10);
      cs_set(1'b1);
   endtask : frame
   task automatic abort_at(input int nb);
      logic s;
      cs_set(1'b0);
      for (int i = 0; i < nb; i++) bit_io(1'b1, 1'b1, s);
      cs_set(1'b1);
   endtask : abort_at
endmodule : spi_host_model

//--- sim/tb.sv
// self-checking bench for the serial configuration register map
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
   $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb
   import spi_cfg_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic sclk, cs_n, sdio_line, sdio_out, sdio_oe, lsb_first;
   settings_t settings;
   int num_errors = 0;
   int check_count = 0;
   int cyc_n = 0;
   logic [31:0] seed = 32'h7D9E;
   logic [7:0] hold_m [256];
   logic [7:0] act_m [256];
   logic [7:0] r;
   initial forever #50 sys_clk = ~sys_clk;
   spi_cfg_regs DUT (.sys_clk(sys_clk), .rst_b(rst_b), .sclk(sclk), .chip_select_n(cs_n),
      .sdio_in(sdio_line), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .lsb_first(lsb_first),
      .settings(settings));
   spi_host_model host (.sys_clk(sys_clk), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
      .sclk(sclk), .chip_select_n(cs_n), .sdio_line(sdio_line));
   function automatic void m_reset();
      foreach (hold_m[i]) hold_m[i] = 8'h00;
      hold_m[0] = PORT_RST;
      hold_m[5] = INDEX_RST;
      hold_m[9] = CLOCK_RST;
      act_m = hold_m;
   endfunction : m_reset
   function automatic logic mapped(input int a);
      return a == 0 || a == 5 || (a >= 8 && a <= 8'h22);
   endfunction : mapped
   function automatic logic [7:0] m_read(input int a);
      if (a == 1) return PART_ID_DEF;
      if (a == 2) return {1'b0, GRADE_DEF, 4'h0};
      return mapped(a) ? hold_m[a] : 8'h00;
   endfunction : m_read
   function automatic void m_write(input int a, input logic [7:0] d);
      if (a == 0 && (d[PORT_SRST_HI] || d[PORT_SRST_LO])) m_reset();
      else if (mapped(a)) hold_m[a] = d;
      else if (a == 8'hFF && d[XFER_BIT]) act_m = hold_m;
   endfunction : m_write
   function automatic settings_t m_set();
      settings_t s;
      s.dev_index = act_m[5];
      for (int i = 0; i < FUNC_N; i++) s.funcs[i] = act_m[8 + i];
      return s;
   endfunction : m_set
   function automatic logic [7:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : xs
   task automatic acc(input logic rd, input logic st, input int a, input int n);
      int ad;
      if (rd) host.dq.delete();
      host.frame(rd, st ? 2'b11 : 2'(n - 1), 13'(a), n);
      for (int k = 0; k < n; k++) begin
         ad = host.lsb ? a + k : a - k;
         if (rd) begin
            r = m_read(ad) & (ad == 2 ? 8'h70 : 8'hFF);
            `CHK("rdata", r, host.dq[k] & (ad == 2 ? 8'h70 : 8'hFF))
         end else m_write(ad, host.dq[k]);
      end
      `CHK("settings", m_set(), settings)
      `CHK("lsb_first", hold_m[0][PORT_LSB_HI], lsb_first)
      `CHK("sdio_oe", 1'b0, sdio_oe)
   endtask : acc
   task automatic wr(input int a, input logic [7:0] d);
      host.dq = {d};
      acc(1'b0, 1'b0, a, 1);
   endtask : wr
   task automatic rd1(input int a);
      acc(1'b1, 1'b0, a, 1);
   endtask : rd1
   task automatic endt(input string nm);
      $display("test %s done, errors %0d", nm, num_errors);
   endtask : endt
   task automatic complete_run();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : complete_run
   // ceiling well above the roughly 22k cycles the sequence needs
   always @(posedge sys_clk) begin
      cyc_n++;
      if (cyc_n == 80000) begin
         num_errors++;
         complete_run();
      end
   end
   initial begin
      m_reset();
      repeat (10) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (10) @(posedge sys_clk);
      `CHK("reset settings", SET_RST, settings)
      `CHK("clock reg", CLOCK_RST, settings.funcs[CLOCK_IDX])
      for (int a = 0; a < 3; a++) rd1(a);
      endt("defaults");
      wr(1, xs());
      wr(2, xs());
      rd1(1);
      rd1(2);
      endt("read_only");
      wr(8, 8'h00);
      wr(9, 8'h00);
      rd1(9);
      wr(8'hFF, 8'h01);
      endt("transfer");
      for (int i = 0; i < 12; i++) wr(i % 4 == 0 ? 5 : 8 + int'(xs()) % FUNC_N, xs());
      host.dq = {xs(), xs(), xs()};
      acc(1'b0, 1'b1, 8'h22, 3);
      wr(8'h30, 8'h00);
      rd1(8'h30);
      rd1(3);
      rd1(8'hFF);
      wr(8'hFF, 8'h01);
      acc(1'b1, 1'b1, 2, 3);
      endt("bank");
      host.abort_at(5);
      rd1(0);
      endt("abort");
      wr(0, 8'h5A);
      host.lsb = 1'b1;
      acc(1'b1, 1'b1, 0, 3);
      wr(0, 8'h18);
      host.lsb = 1'b0;
      endt("bit_order");
      wr(8'h0A, 8'h55);
      wr(8'hFF, 8'h01);
      wr(0, 8'h3C);
      rd1(8'h0A);
      endt("soft_reset");
      wr(9, 8'h00);
      wr(8'hFF, 8'h01);
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      m_reset();
      repeat (10) @(posedge sys_clk);
      `CHK("rereset settings", SET_RST, settings)
      endt("second_reset");
      complete_run();
   end
endmodule : tb
